// ### common/pcc_pkg.sv
// Purpose: Shared constants for the card configuration block
// Assumes: 32-bit AXI4-Lite register port, 100 MHz aclk
// Notes: Byte addresses are the printed attribute offsets
`default_nettype none
package pcc_pkg;
   // Register byte addresses
   localparam logic [11:0] COR_OFF = 12'h200;
   localparam logic [11:0] STAT_OFF = 12'h210;
   localparam logic [11:0] MASK_OFF = 12'h214;
   localparam logic [11:0] INFO_OFF = 12'h218;
   // Configuration option fields
   localparam int COR_RESET_BIT = 7;
   localparam int COR_LEVEL_BIT = 6;
   localparam int MODE_W = 6;
   localparam logic [7:0] COR_RST = 8'h00;
   localparam logic [7:0] COR_CARD_RESET_REQUEST_VAL = 8'h80;
   localparam logic [2:0] MASK_RST = 3'h0;
   // Status bit positions: sticky events, then live direct and in-reset bits
   localparam int ST_SRST = 0;
   localparam int ST_MODE = 1;
   localparam int ST_IRQ = 2;
   localparam int ST_DIRECT = 8;
   localparam int ST_INRST = 9;
   typedef enum logic [5:0] {
      MODE_MEM = 6'h00,
      MODE_CONTIG = 6'h01,
      MODE_PRI = 6'h02,
      MODE_SEC = 6'h03
   } pcc_mode_t;
   // Task file windows
   localparam logic [9:0] PRI_BLK = 10'h1f0;
   localparam logic [9:0] PRI_ALT = 10'h3f6;
   localparam logic [9:0] SEC_BLK = 10'h170;
   localparam logic [9:0] SEC_ALT = 10'h376;
   // Information structure tail and advertised features
   localparam logic [7:0] CIS_NOLINK = 8'h14;
   localparam logic [7:0] CIS_NOLINK_LEN = 8'h00;
   localparam logic [7:0] CIS_END = 8'hff;
   localparam logic [4:0] IRQ_LINE = 5'h0e;
   localparam logic [2:0] FEAT_PD_AUD_RO = 3'h1;
   // Timing
   localparam int CLK_NS = 10;
   localparam int IRQ_PULSE_NS = 100;
   localparam logic [7:0] IRQ_PULSE_CYC = 8'(IRQ_PULSE_NS / CLK_NS);
   localparam logic [1:0] STRAP_WAIT = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### common/pcc_dec_if.sv
// Purpose: Link between the register bank and the task file decoder
// Assumes: Both ends on aclk
// Notes: Decoder answers one cycle after acc_valid
`default_nettype none
interface pcc_dec_if;
   logic [5:0] mode;
   logic direct;
   logic in_reset;
   logic acc_valid;
   logic [10:0] acc_addr;
   logic acc_io;
   logic acc_wide;
   logic tf_valid;
   logic tf_hit;
   logic tf_wide;
   logic [3:0] tf_off;
   modport cfg(output mode, direct, in_reset, acc_valid, acc_addr, acc_io,
      acc_wide, input tf_valid, tf_hit, tf_wide, tf_off);
   modport dec(input mode, direct, in_reset, acc_valid, acc_addr, acc_io,
      acc_wide, output tf_valid, tf_hit, tf_wide, tf_off);
endinterface
`default_nettype wire

// ### src/pcc_tf_decode.sv
// Purpose: Task file address decoder per interface mode
// Assumes: Mode comes from the live option register
// Notes: Result is registered, one cycle after the access
`default_nettype none
module pcc_tf_decode (
   input wire logic aclk,
   input wire logic aresetn,
   pcc_dec_if.dec dif
);
   typedef struct packed {
      logic v;
      logic hit;
      logic wide;
      logic [3:0] off;
   } pcc_dec_st_t;
   pcc_dec_st_t st_ff;
   pcc_dec_st_t nxt_st;
   logic [4:0] fix;

   // Only ten address lines take part in the fixed windows
   function automatic logic [4:0] fix_dec(input logic [10:0] a,
      input logic [9:0] blk, input logic [9:0] alt);
      if (a[9:3] == blk[9:3]) begin
         return {2'b10, a[2:0]};
      end
      if (a[9:1] == alt[9:1]) begin
         return {4'b1111, a[0]};
      end
      return 5'h00;
   endfunction

   always_comb begin
      nxt_st = '0;
      fix = 5'h00;
      nxt_st.off = dif.acc_addr[3:0];
      if (dif.direct) begin
         nxt_st.hit = 1'b1;
      end else begin
         case (dif.mode)
            pcc_pkg::MODE_MEM: begin
               nxt_st.hit = !dif.acc_io &&
                  (dif.acc_addr[10] || dif.acc_addr[9:4] == 6'h00);
            end
            pcc_pkg::MODE_CONTIG: begin
               nxt_st.hit = dif.acc_io;
            end
            pcc_pkg::MODE_PRI: begin
               fix = fix_dec(dif.acc_addr, pcc_pkg::PRI_BLK,
                  pcc_pkg::PRI_ALT);
               nxt_st.hit = dif.acc_io && fix[4];
               nxt_st.off = fix[3:0];
            end
            pcc_pkg::MODE_SEC: begin
               fix = fix_dec(dif.acc_addr, pcc_pkg::SEC_BLK,
                  pcc_pkg::SEC_ALT);
               nxt_st.hit = dif.acc_io && fix[4];
               nxt_st.off = fix[3:0];
            end
            default: begin
               nxt_st.hit = 1'b0;
            end
         endcase
      end
      // Live mode field decides each access outside direct mode
      nxt_st.v = dif.acc_valid;
      nxt_st.hit = nxt_st.hit && dif.acc_valid && !dif.in_reset;
      nxt_st.wide = nxt_st.hit && dif.acc_wide;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign dif.tf_valid = st_ff.v;
   assign dif.tf_hit = st_ff.hit;
   assign dif.tf_wide = st_ff.wide;
   assign dif.tf_off = st_ff.off;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_pri_blk;
      dif.acc_valid && dif.acc_io && !dif.direct && !dif.in_reset &&
         dif.mode == pcc_pkg::MODE_PRI && dif.acc_addr[9:3] == 7'h3e;
   endsequence

   a_pri_block_hit: assert property (
      s_pri_blk |=> dif.tf_hit &&
         dif.tf_off == {1'b0, $past(dif.acc_addr[2:0])})
      else $error("primary block access not decoded");
   a_sec_alt_hit: assert property (
      dif.acc_valid && dif.acc_io && !dif.direct && !dif.in_reset &&
      dif.mode == pcc_pkg::MODE_SEC && dif.acc_addr[9:1] == 9'h1bb
      |=> dif.tf_hit && dif.tf_off[3:1] == 3'b111)
      else $error("secondary alternate access not decoded");
   a_mem_dup_hit: assert property (
      dif.acc_valid && !dif.acc_io && !dif.direct && !dif.in_reset &&
      dif.mode == pcc_pkg::MODE_MEM && dif.acc_addr[10]
      |=> dif.tf_hit)
      else $error("memory duplicate window not decoded");
endmodule // pcc_tf_decode
`default_nettype wire

// ### src/pcc_cfg_top.sv
// Purpose: Card configuration option register bank with AXI4-Lite access
// Assumes: Host access strobes come from logic on aclk; strap is a pin
// Notes: Writes and reads take one transfer at a time
`default_nettype none
// Contract
// - Registers usable in memory/IO, locked in direct mode; only the option register is locked, status, mask and info stay usable
// - Writing reset bit one resets like hardware
// - Reset bit stays until host clears it
// - Bit six chooses pulse or level interrupt
// - Six low bits select interface mode
// - Any reset forces mode field to zero
// - Memory mode decodes 0-F and 400-7FF
// - Mode one contiguous; mode two primary window
// - Mode three decodes secondary window
// - Fixed IO decodes ten lines, 8/16 bit
// - Eight-byte and two-byte blocks per window
// - Fixed IO interrupts only on line fourteen
// - Shareable interrupt in pulse and level
// - Power-down yes, audio no, not read-only
// - Structure ends no-link 14, then FF
// - Output enable low at power-up selects direct
module pcc_cfg_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic oe_n_pin,
   input wire logic acc_valid,
   input wire logic [10:0] acc_addr,
   input wire logic acc_io,
   input wire logic acc_wide,
   output logic tf_valid,
   output logic tf_hit,
   output logic tf_wide,
   output logic [3:0] tf_offset,
   input wire logic card_irq_src,
   output logic irq14_o,
   output logic irq14_oe,
   output logic card_reset_request,
   output logic level_irq_select,
   output logic [5:0] interface_mode,
   output logic direct_disk_interface_mode,
   output logic irq
);
   typedef struct packed {
      logic [7:0] cor;
      logic [2:0] sts;
      logic [2:0] msk;
      logic aw_got;
      logic [11:0] awa;
      logic w_got;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic s1;
      logic s2;
      logic [1:0] scnt;
      logic direct;
      logic src_q;
      logic [7:0] pcnt;
      logic irq_oe;
   } pcc_st_t;

   pcc_st_t st_ff;
   pcc_st_t nxt_st;
   logic wr_go;
   logic rd_go;
   logic cor_wr;
   logic [7:0] cor_new;
   logic [2:0] set;
   logic [2:0] clr;
   logic irq_en;
   logic lvl;

   pcc_dec_if dif ();

   pcc_tf_decode u_dec (
      .aclk(aclk),
      .aresetn(aresetn),
      .dif(dif)
   );

   assign dif.mode = st_ff.cor[5:0];
   assign dif.direct = st_ff.direct;
   assign dif.in_reset = st_ff.cor[pcc_pkg::COR_RESET_BIT];
   assign dif.acc_valid = acc_valid;
   assign dif.acc_addr = acc_addr;
   assign dif.acc_io = acc_io;
   assign dif.acc_wide = acc_wide;

   assign lvl = st_ff.cor[pcc_pkg::COR_LEVEL_BIT];
   // Interrupt drives in any mode but memory, or in direct mode, and out of reset
   assign irq_en = (st_ff.cor[5:0] != pcc_pkg::MODE_MEM || st_ff.direct) &&
      !st_ff.cor[pcc_pkg::COR_RESET_BIT];
   assign wr_go = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign cor_wr = wr_go && st_ff.awa == pcc_pkg::COR_OFF &&
      !st_ff.direct && st_ff.ws[0];

   always_comb begin
      nxt_st = st_ff;
      set = 3'h0;
      clr = 3'h0;
      cor_new = st_ff.wd[7:0];
      // Soft reset clears the option fields as hard reset does but keeps its own bit set; mask, status and strap are kept
      if (st_ff.wd[pcc_pkg::COR_RESET_BIT]) begin
         cor_new = pcc_pkg::COR_CARD_RESET_REQUEST_VAL;
      end

      // Strap: wait for the synchroniser to fill before sampling
      nxt_st.s1 = oe_n_pin;
      nxt_st.s2 = st_ff.s1;
      if (st_ff.scnt != 2'h3) begin
         nxt_st.scnt = st_ff.scnt + 2'h1;
      end
      if (st_ff.scnt == pcc_pkg::STRAP_WAIT) begin
         nxt_st.direct = !st_ff.s2;
      end

      // Write address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wd = s_axi_wdata;
         nxt_st.ws = s_axi_wstrb;
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (wr_go) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = pcc_pkg::RESP_OKAY;
         if (st_ff.awa == pcc_pkg::COR_OFF) begin
            if (st_ff.direct) begin
               nxt_st.bresp = pcc_pkg::RESP_SLVERR;
            end else if (st_ff.ws[0]) begin
               // Bit stays until the host writes it back
               nxt_st.cor = cor_new;
            end
         end else if (st_ff.awa == pcc_pkg::MASK_OFF) begin
            if (st_ff.ws[0]) begin
               nxt_st.msk = st_ff.wd[2:0];
            end
         end else if (st_ff.awa == pcc_pkg::STAT_OFF ||
            st_ff.awa == pcc_pkg::INFO_OFF) begin
            nxt_st.bresp = pcc_pkg::RESP_OKAY;
         end else begin
            nxt_st.bresp = pcc_pkg::RESP_SLVERR;
         end
      end

      // Reads
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (rd_go) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = 32'h0;
         nxt_st.rresp = pcc_pkg::RESP_OKAY;
         if (s_axi_araddr == pcc_pkg::COR_OFF) begin
            if (st_ff.direct) begin
               nxt_st.rresp = pcc_pkg::RESP_SLVERR;
            end else begin
               nxt_st.rdata = {24'h0, st_ff.cor};
            end
         end else if (s_axi_araddr == pcc_pkg::STAT_OFF) begin
            nxt_st.rdata[2:0] = st_ff.sts;
            nxt_st.rdata[pcc_pkg::ST_DIRECT] = st_ff.direct;
            nxt_st.rdata[pcc_pkg::ST_INRST] =
               st_ff.cor[pcc_pkg::COR_RESET_BIT];
            clr = 3'h7;
         end else if (s_axi_araddr == pcc_pkg::MASK_OFF) begin
            nxt_st.rdata[2:0] = st_ff.msk;
         end else if (s_axi_araddr == pcc_pkg::INFO_OFF) begin
            // Structure tail and feature summary
            nxt_st.rdata = {pcc_pkg::FEAT_PD_AUD_RO, pcc_pkg::IRQ_LINE,
               pcc_pkg::CIS_END, pcc_pkg::CIS_NOLINK_LEN,
               pcc_pkg::CIS_NOLINK};
         end else begin
            nxt_st.rresp = pcc_pkg::RESP_SLVERR;
         end
      end

      // Interrupt request generation
      nxt_st.src_q = card_irq_src;
      if (!irq_en) begin
         nxt_st.pcnt = 8'h00;
         nxt_st.irq_oe = 1'b0;
      end else if (lvl) begin
         nxt_st.pcnt = 8'h00;
         nxt_st.irq_oe = card_irq_src;
      end else begin
         if (card_irq_src && !st_ff.src_q) begin
            nxt_st.pcnt = pcc_pkg::IRQ_PULSE_CYC;
         end else if (st_ff.pcnt != 8'h00) begin
            nxt_st.pcnt = st_ff.pcnt - 8'h01;
         end
         nxt_st.irq_oe = nxt_st.pcnt != 8'h00;
      end

      // Sticky events; a set in the clearing cycle survives
      set[pcc_pkg::ST_SRST] = cor_wr &&
         st_ff.wd[pcc_pkg::COR_RESET_BIT] &&
         !st_ff.cor[pcc_pkg::COR_RESET_BIT];
      set[pcc_pkg::ST_MODE] = cor_wr && cor_new[5:0] != st_ff.cor[5:0];
      set[pcc_pkg::ST_IRQ] = card_irq_src && !st_ff.src_q;
      nxt_st.sts = (st_ff.sts & ~clr) | set;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
         st_ff.cor <= pcc_pkg::COR_RST;
         st_ff.msk <= pcc_pkg::MASK_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
   assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_arready = !st_ff.rvalid;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;

   assign tf_valid = dif.tf_valid;
   assign tf_hit = dif.tf_hit;
   assign tf_wide = dif.tf_wide;
   assign tf_offset = dif.tf_off;

   // Shared line: only pull low, otherwise release
   assign irq14_o = 1'b0;
   assign irq14_oe = st_ff.irq_oe;
   assign card_reset_request = st_ff.cor[pcc_pkg::COR_RESET_BIT];
   assign level_irq_select = lvl;
   assign interface_mode = st_ff.cor[5:0];
   assign direct_disk_interface_mode = st_ff.direct;
   assign irq = |(st_ff.sts & st_ff.msk);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_pulse_start;
      irq_en && !lvl && card_irq_src && !st_ff.src_q;
   endsequence
   sequence s_pulse_body;
      st_ff.irq_oe [*8];
   endsequence
   sequence s_cor_card_reset_request_write;
      cor_wr && st_ff.wd[pcc_pkg::COR_RESET_BIT];
   endsequence

   a_card_reset_request_clears_mode: assert property (
      s_cor_card_reset_request_write |=> card_reset_request && interface_mode == 6'h00
         && !level_irq_select)
      else $error("soft reset did not clear option fields");
   a_card_reset_request_holds: assert property (
      card_reset_request && !cor_wr |=> card_reset_request)
      else $error("reset request bit cleared by itself");
   a_direct_locks_cor: assert property (
      st_ff.direct && !$rose(st_ff.direct) |=> $stable(st_ff.cor))
      else $error("option register changed in direct mode");
   a_pulse_irq_width: assert property (
      s_pulse_start |=> s_pulse_body)
      else $error("pulse interrupt too short");
   a_level_irq_follow: assert property (
      (irq_en && lvl && card_irq_src) [*2] |-> irq14_oe)
      else $error("level interrupt not driven");
   a_irq_only_io: assert property (
      irq14_oe |-> $past(irq_en))
      else $error("interrupt driven outside I/O modes");
   a_mode_write_next: assert property (
      cor_wr && !st_ff.wd[pcc_pkg::COR_RESET_BIT]
      |=> interface_mode == $past(st_ff.wd[5:0]))
      else $error("mode field not taken from write");
   a_write_resp_time: assert property (
      wr_go |=> s_axi_bvalid ##0 !s_axi_awready)
      else $error("write response missing");
   a_stat_read_clear: assert property (
      rd_go && s_axi_araddr == pcc_pkg::STAT_OFF && !card_irq_src && !cor_wr
      |=> st_ff.sts == 3'h0)
      else $error("status not cleared by read");
   a_sts_set_wins: assert property (
      set[pcc_pkg::ST_IRQ] |=> st_ff.sts[pcc_pkg::ST_IRQ])
      else $error("interrupt event lost to status read");
   a_read_resp_time: assert property (
      rd_go |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response missing");
   a_info_tail: assert property (
      rd_go && s_axi_araddr == pcc_pkg::INFO_OFF
      |=> s_axi_rdata[23:0] == 24'hff0014)
      else $error("structure tail read wrong");

   // Direct mode refuses option writes with an error
   a_direct_cor_err: assert property (
      wr_go && st_ff.awa == pcc_pkg::COR_OFF && st_ff.direct
      |=> s_axi_bvalid && s_axi_bresp == pcc_pkg::RESP_SLVERR)
      else $error("option write in direct mode not refused");

   // Strap taken once per hard reset; soft reset keeps it
   a_strap_once: assert property (
      st_ff.scnt == 2'h3 |=> $stable(st_ff.direct))
      else $error("direct mode changed after strap");

   // Line stays released in memory mode outside direct mode, and during reset
   a_mem_no_irq: assert property (
      !irq_en |=> !irq14_oe)
      else $error("interrupt driven while disabled");
   a_level_irq_drop: assert property (
      irq_en && lvl && !card_irq_src |=> !irq14_oe)
      else $error("level interrupt not released");

   // Last count of a pulse with no new rise behind it
   sequence s_pulse_last;
      irq_en && !lvl && st_ff.pcnt == 8'h01 &&
         !(card_irq_src && !st_ff.src_q);
   endsequence
   a_pulse_irq_stop: assert property (
      s_pulse_last |=> !st_ff.irq_oe)
      else $error("pulse interrupt too long");
endmodule // pcc_cfg_top
`default_nettype wire

// ### bench/pcc_host_model.sv
// Purpose: Host socket model driving task file accesses and the strap
// Assumes: Same clock as the card; strobes change after rising edges
// Notes: Idle address lines show the inverse of the last value
`default_nettype none
module pcc_host_model (
   input wire logic aclk,
   output var logic oe_n_pin,
   output var logic acc_valid,
   output var logic [10:0] acc_addr,
   output var logic acc_io,
   output var logic acc_wide,
   input wire logic tf_valid,
   input wire logic tf_hit,
   input wire logic tf_wide,
   input wire logic [3:0] tf_offset
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      oe_n_pin = 1'b1;
      acc_valid = 1'b0;
      acc_addr = 11'h000;
      acc_io = 1'b0;
      acc_wide = 1'b0;
   end
   // Called just before reset; the pin changes in the same cycle as aresetn falls
   task automatic strap(input logic lvl);
      @(posedge aclk);
      oe_n_pin <= lvl;
   endtask
   // One-cycle strobe; the answer is sampled one edge later
   task automatic access(input logic [10:0] a, input logic io,
      input logic wide, output logic v, output logic h, output logic w,
      output logic [3:0] o);
      @(posedge aclk);
      acc_valid <= 1'b1;
      acc_addr <= a;
      acc_io <= io;
      acc_wide <= wide;
      @(posedge aclk);
      acc_valid <= 1'b0;
      acc_addr <= ~a;
      acc_io <= ~io;
      acc_wide <= ~wide;
      @(posedge aclk);
      v = tf_valid;
      h = tf_hit;
      w = tf_wide;
      o = tf_offset;
   endtask
endmodule // pcc_host_model
`default_nettype wire

// ### bench/pc_card_config_option_reg_test.sv
// Purpose: Self-checking bench for the card configuration block
// Assumes: AXI4-Lite master waits on handshakes, bounded by a count
// Notes: Every driving task starts at a clock edge to avoid double drives
`default_nettype none
module pc_card_config_option_reg_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, src, irq14_o, irq14_oe;
   logic oe_n, acc_valid, acc_io, acc_wide, tf_valid, tf_hit, tf_wide;
   logic rst_req, lvl_sel, direct, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, tf_offset;
   logic [1:0] bresp, rresp;
   logic [10:0] acc_addr;
   logic [5:0] imode;
   int err_total, total_checks;
   localparam logic [1:0] OK = 2'h0;
   localparam logic [1:0] ERR = 2'h2;
   pcc_cfg_top i_pcc_cfg_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .oe_n_pin(oe_n), .acc_valid(acc_valid),
      .acc_addr(acc_addr), .acc_io(acc_io), .acc_wide(acc_wide),
      .tf_valid(tf_valid), .tf_hit(tf_hit), .tf_wide(tf_wide),
      .tf_offset(tf_offset), .card_irq_src(src), .irq14_o(irq14_o),
      .irq14_oe(irq14_oe), .card_reset_request(rst_req),
      .level_irq_select(lvl_sel), .interface_mode(imode),
      .direct_disk_interface_mode(direct), .irq(irq));
   pcc_host_model i_pcc_host_model (.aclk(aclk), .oe_n_pin(oe_n),
      .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_io(acc_io),
      .acc_wide(acc_wide), .tf_valid(tf_valid), .tf_hit(tf_hit),
      .tf_wide(tf_wide), .tf_offset(tf_offset));
   always #5 aclk = ~aclk;
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp, input string m);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic hang(input string m);
      err_total++;
      $display("BAD %0t no answer on %s", $time, m);
      end_of_test();
   endtask
   task automatic wrchk(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] er);
      logic aw_p, w_p, got;
      aw_p = 1'b1;
      w_p = 1'b1;
      got = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 50 && !got; n++) begin
         @(posedge aclk);
         if (aw_p && awready) begin
            aw_p = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_p && wready) begin
            w_p = 1'b0;
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            got = 1'b1;
            bready <= 1'b0;
            chk({30'h0, bresp}, {30'h0, er}, "write response");
         end
      end
      if (!got) hang("write");
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] msk,
      input logic [31:0] ed, input logic [1:0] er);
      logic got;
      got = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 50 && !got; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            got = 1'b1;
            rready <= 1'b0;
            chk(rdata & msk, ed, "read data");
            chk({30'h0, rresp}, {30'h0, er}, "read response");
         end
      end
      if (!got) hang("read");
   endtask
   task automatic tfc(input logic [10:0] a, input logic io, wide, hit,
      input logic [3:0] off);
      logic v, h, w;
      logic [3:0] o;
      i_pcc_host_model.access(a, io, wide, v, h, w, o);
      chk({25'h0, v, h, w, h ? o : 4'h0},
         {25'h0, 1'b1, hit, hit & wide, hit ? off : 4'h0}, "decode");
   endtask
   task automatic do_reset(input logic strap_lvl);
      i_pcc_host_model.strap(strap_lvl);
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (6) @(posedge aclk);
   endtask
   task automatic t_reset_vals;
      rdchk(12'h200, 32'hff, 32'h0, OK);
      rdchk(pcc_pkg::STAT_OFF, 32'hffffffff, 32'h0, OK);
      rdchk(pcc_pkg::MASK_OFF, 32'h7, 32'h0, OK);
      rdchk(pcc_pkg::INFO_OFF, 32'hffffffff, 32'h2eff0014, OK);
      chk({29'h0, irq, irq14_oe, irq14_o}, 32'h0, "idle irq");
      rdchk(12'h300, 32'hffffffff, 32'h0, ERR);
   endtask
   task automatic t_decode;
      wrchk(12'h200, 32'h0, OK);
      tfc(11'h00f, 1'b0, 1'b0, 1'b1, 4'hf);
      tfc(11'h400, 1'b0, 1'b1, 1'b1, 4'h0);
      tfc(11'h7fd, 1'b0, 1'b0, 1'b1, 4'hd);
      tfc(11'h010, 1'b0, 1'b0, 1'b0, 4'h0);
      wrchk(12'h200, 32'h1, OK);
      chk({26'h0, imode}, 32'h1, "mode port");
      tfc(11'h2a7, 1'b1, 1'b0, 1'b1, 4'h7);
      wrchk(12'h200, 32'h2, OK);
      tfc(11'h1f0, 1'b1, 1'b1, 1'b1, 4'h0);
      tfc(11'h1f7, 1'b1, 1'b0, 1'b1, 4'h7);
      tfc(11'h3f6, 1'b1, 1'b0, 1'b1, 4'he);
      tfc(11'h3f7, 1'b1, 1'b1, 1'b1, 4'hf);
      tfc(11'h5f3, 1'b1, 1'b0, 1'b1, 4'h3);
      tfc(11'h1f8, 1'b1, 1'b0, 1'b0, 4'h0);
      tfc(11'h3f5, 1'b1, 1'b0, 1'b0, 4'h0);
      tfc(11'h170, 1'b1, 1'b0, 1'b0, 4'h0);
      wrchk(12'h200, 32'h3, OK);
      tfc(11'h177, 1'b1, 1'b0, 1'b1, 4'h7);
      tfc(11'h377, 1'b1, 1'b1, 1'b1, 4'hf);
      tfc(11'h178, 1'b1, 1'b0, 1'b0, 4'h0);
      tfc(11'h1f0, 1'b1, 1'b0, 1'b0, 4'h0);
      wrchk(12'h200, 32'h4, OK);
      tfc(11'h1f0, 1'b1, 1'b0, 1'b0, 4'h0);
   endtask
   task automatic t_soft_reset;
      wrchk(12'h200, 32'h42, OK);
      rdchk(pcc_pkg::STAT_OFF, 32'h307, 32'h2, OK);
      wrchk(12'h200, 32'hc2, OK);
      rdchk(12'h200, 32'hff, 32'h80, OK);
      tfc(11'h1f3, 1'b1, 1'b0, 1'b0, 4'h0);
      rdchk(pcc_pkg::STAT_OFF, 32'h201, 32'h201, OK);
      repeat (20) @(posedge aclk);
      chk({31'h0, rst_req}, 32'h1, "reset bit kept");
      wrchk(12'h200, 32'h2, OK);
      rdchk(12'h200, 32'hff, 32'h2, OK);
      tfc(11'h1f3, 1'b1, 1'b0, 1'b1, 4'h3);
   endtask
   task automatic t_irq;
      int cnt;
      wrchk(12'h200, 32'h42, OK);
      wrchk(pcc_pkg::MASK_OFF, 32'h4, OK);
      rdchk(pcc_pkg::STAT_OFF, 32'h307, 32'h2, OK);
      chk({30'h0, rst_req, lvl_sel}, 32'h1, "level select");
      src <= 1'b1;
      repeat (2) @(posedge aclk);
      chk({30'h0, irq14_oe, irq}, 32'h3, "level drive");
      chk({31'h0, irq14_o}, 32'h0, "line level");
      src <= 1'b0;
      repeat (2) @(posedge aclk);
      chk({31'h0, irq14_oe}, 32'h0, "level release");
      rdchk(pcc_pkg::STAT_OFF, 32'h4, 32'h4, OK);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      for (int m = 0; m < 2; m++) begin
         wrchk(12'h200, m == 0 ? 32'h2 : 32'h40, OK);
         cnt = 0;
         @(posedge aclk);
         src <= 1'b1;
         repeat (20) begin
            @(posedge aclk);
            if (irq14_oe === 1'b1) cnt++;
         end
         src <= 1'b0;
         chk(cnt, m == 0 ? 10 : 0, "pulse length");
      end
   endtask
   task automatic t_direct;
      do_reset(1'b0);
      chk({31'h0, direct}, 32'h1, "strap direct");
      rdchk(12'h200, 32'hffffffff, 32'h0, ERR);
      wrchk(12'h200, 32'h42, ERR);
      rdchk(pcc_pkg::STAT_OFF, 32'h100, 32'h100, OK);
      tfc(11'h2a7, 1'b1, 1'b0, 1'b1, 4'h7);
      do_reset(1'b1);
      chk({31'h0, direct}, 32'h0, "strap card");
      rdchk(12'h200, 32'hff, 32'h0, OK);
   endtask
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, src} = '0;
      awaddr = 12'h0;
      araddr = 12'h0;
      wdata = 32'h0;
      wstrb = 4'hf;
      err_total = 0;
      total_checks = 0;
      do_reset(1'b1);
      t_reset_vals();
      t_decode();
      t_soft_reset();
      t_irq();
      t_direct();
      end_of_test();
   end
endmodule // pc_card_config_option_reg_test
`default_nettype wire
